// *** fiber_np_pkg.sv ***
// Purpose: Shared constants and carriers for the fiber next-page register bank
// Assumes: 32-bit AXI4-Lite, registers in the low 16 bits of each word
// Notes: Printed offsets are not multiples of four, so byte address = index * 4
package fiber_np_pkg;
    localparam logic [3:0] IDX_EXPANSION = 4'h6;
    localparam logic [3:0] IDX_NP_TX = 4'h7;
    localparam logic [3:0] IDX_PARTNER_NP = 4'h8;
    localparam logic [3:0] IDX_MODE_CTRL = 4'h9;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'hA;
    localparam logic [3:0] IDX_IRQ_MASK = 4'hB;

    localparam logic [1:0] MODE_100FX = 2'h0;
    localparam logic [1:0] MODE_1000X = 2'h1;
    localparam logic [1:0] MODE_SER_SYS = 2'h2;
    localparam logic [1:0] MODE_SER_MEDIA = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h1;

    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PARTNER_AN = 0;

    localparam int CW_NEXT_PAGE = 15;
    localparam int CW_ACK = 14;
    localparam int CW_MSG_PAGE = 13;
    localparam int CW_ACK2 = 12;
    localparam int CW_TOGGLE = 11;

    localparam logic NP_MSG_PAGE_RESET = 1'h1;
    localparam logic [10:0] NP_FIELD_RESET = 11'h001;
    localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;
    localparam int CFG_MATCH_COUNT = 3;

    localparam int IRQ_PAGE_RX = 0;
    localparam int IRQ_PARTNER_NP = 1;
    localparam int IRQ_LINK_DOWN = 2;
    localparam int IRQ_BITS = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic next_page;
        logic msg_page;
        logic second_ack_flag;
        logic toggle;
        logic [10:0] field;
    } np_tx_s;

    typedef struct packed {
        logic valid;
        logic is_next_page;
        logic [15:0] word;
    } rx_page_s;
endpackage : fiber_np_pkg

// *** fiber_autoneg_next_page.sv ***
// Purpose: Fiber auto-negotiation expansion and next-page register bank
// Assumes: Page events come from the negotiation engine on aclk
// Notes: AXI4-Lite slave; one write and one read in flight at a time
`timescale 1ns/1ps
`default_nettype none
module fiber_autoneg_next_page
    import fiber_np_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sw_reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rx_page_s rx_page,
    input wire logic link_down,
    input wire logic rx_sync,
    input wire logic cfg_word_valid,
    input wire logic [15:0] cfg_word,
    input wire logic an_enable,
    output np_tx_s tx_next_page,
    output logic next_page_loaded,
    output logic np_tx_active,
    output logic [1:0] fiber_mode,
    output logic irq
);
    typedef struct packed {
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] mode;
        np_tx_s np_tx;
        logic [15:0] partner_np;
        logic partner_np_able;
        logic page_rx;
        logic partner_an_able;
        logic [15:0] last_cfg;
        logic [1:0] cfg_matches;
        logic np_loaded;
        logic [IRQ_BITS-1:0] irq_status;
        logic [IRQ_BITS-1:0] irq_mask;
        logic irq;
    } state_s;

    state_s cur;
    state_s nxt;

    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        reg_index = addr[5:2];
    endfunction : reg_index

    function automatic logic mapped(input logic [31:0] addr);
        mapped = (addr[31:6] == 26'h0) && (addr[1:0] == 2'h0)
            && (reg_index(addr) >= IDX_EXPANSION) && (reg_index(addr) <= IDX_IRQ_MASK);
    endfunction : mapped

    function automatic logic [15:0] expansion_word(input state_s s);
        expansion_word = 16'h0000;
        expansion_word[EXP_PARTNER_NP] = (s.mode == MODE_1000X) && s.partner_np_able;
        expansion_word[EXP_LOCAL_NP] = 1'b1;
        expansion_word[EXP_PAGE_RX] = s.page_rx;
        expansion_word[EXP_PARTNER_AN] = s.partner_an_able;
    endfunction : expansion_word

    function automatic logic [15:0] np_tx_word(input np_tx_s t);
        np_tx_word = 16'h0000;
        np_tx_word[CW_NEXT_PAGE] = t.next_page;
        np_tx_word[CW_MSG_PAGE] = t.msg_page;
        np_tx_word[CW_ACK2] = t.second_ack_flag;
        np_tx_word[CW_TOGGLE] = t.toggle;
        np_tx_word[10:0] = t.field;
    endfunction : np_tx_word

    function automatic state_s reset_state();
        reset_state = '0;
        reset_state.mode = MODE_RESET;
        reset_state.np_tx.msg_page = NP_MSG_PAGE_RESET;
        reset_state.np_tx.field = NP_FIELD_RESET;
        reset_state.partner_np = PARTNER_NP_RESET;
    endfunction : reset_state

    logic do_write;
    logic do_read;
    logic [15:0] wr_lo;
    logic [15:0] rd_word;
    logic is_1000x;
    logic page_event;
    logic [IRQ_BITS-1:0] irq_events;

    always_comb begin
        nxt = cur;
        is_1000x = (cur.mode == MODE_1000X);
        page_event = rx_page.valid;
        irq_events = '0;
        nxt.np_loaded = 1'b0;

        // Address and data may arrive in either order; both are held until the write fires
        if (s_axi_awvalid && !cur.aw_held) begin
            nxt.aw_held = 1'b1;
            nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_held) begin
            nxt.w_held = 1'b1;
            nxt.wdata = s_axi_wdata;
            nxt.wstrb = s_axi_wstrb;
        end
        do_write = cur.aw_held && cur.w_held && !cur.bvalid;
        wr_lo = cur.wdata[15:0];
        if (s_axi_bready && cur.bvalid) begin
            nxt.bvalid = 1'b0;
        end

        // Event logic first, so a register write in the same cycle takes the last word
        if (page_event) begin
            nxt.page_rx = 1'b1;
            nxt.np_tx.toggle = ~cur.np_tx.toggle;
            irq_events[IRQ_PAGE_RX] = 1'b1;
            if (!rx_page.is_next_page && is_1000x && rx_page.word[CW_NEXT_PAGE]) begin
                nxt.partner_np_able = 1'b1;
                irq_events[IRQ_PARTNER_NP] = 1'b1;
            end
            if (rx_page.is_next_page && is_1000x) begin
                nxt.partner_np = rx_page.word;
            end
        end

        // Three identical non-zero config words in a row make the partner negotiation-able
        if (!rx_sync || !an_enable) begin
            nxt.cfg_matches = 2'h0;
            nxt.partner_an_able = 1'b0;
        end else if (cfg_word_valid) begin
            nxt.last_cfg = cfg_word;
            if (cfg_word == 16'h0000) begin
                nxt.cfg_matches = 2'h0;
            end else if (cfg_word != cur.last_cfg || cur.cfg_matches == 2'h0) begin
                nxt.cfg_matches = 2'h1;
            end else if (cur.cfg_matches != 2'(CFG_MATCH_COUNT)) begin
                nxt.cfg_matches = cur.cfg_matches + 2'h1;
                if (cur.cfg_matches + 2'h1 == 2'(CFG_MATCH_COUNT)) begin
                    nxt.partner_an_able = 1'b1;
                end
            end
        end

        if (link_down) begin
            nxt.partner_np_able = 1'b0;
            nxt.partner_np = PARTNER_NP_RESET;
            nxt.partner_an_able = 1'b0;
            nxt.cfg_matches = 2'h0;
            irq_events[IRQ_LINK_DOWN] = 1'b1;
        end

        if (do_write) begin
            nxt.aw_held = 1'b0;
            nxt.w_held = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = mapped(cur.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (mapped(cur.awaddr)) begin
                case (reg_index(cur.awaddr))
                    IDX_NP_TX: begin
                        // Low byte lane carries field 7:0, next lane the next-page, message and ack2 flags and field 10:8
                        if (cur.wstrb[0]) begin
                            nxt.np_tx.field[7:0] = wr_lo[7:0];
                        end
                        if (cur.wstrb[1]) begin
                            nxt.np_tx.next_page = wr_lo[CW_NEXT_PAGE];
                            nxt.np_tx.msg_page = wr_lo[CW_MSG_PAGE];
                            nxt.np_tx.second_ack_flag = wr_lo[CW_ACK2];
                            nxt.np_tx.field[10:8] = wr_lo[10:8];
                        end
                        nxt.np_loaded = is_1000x;
                    end
                    IDX_MODE_CTRL: begin
                        if (cur.wstrb[0]) begin
                            nxt.mode = wr_lo[1:0];
                        end
                    end
                    IDX_IRQ_STATUS: begin
                        if (cur.wstrb[0]) begin
                            nxt.irq_status = cur.irq_status & ~wr_lo[IRQ_BITS-1:0];
                        end
                    end
                    IDX_IRQ_MASK: begin
                        if (cur.wstrb[0]) begin
                            nxt.irq_mask = wr_lo[IRQ_BITS-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Set wins over the write-one clear
        nxt.irq_status = nxt.irq_status | irq_events;

        // Read channel: address taken only when no data is pending
        do_read = s_axi_arvalid && !cur.rvalid;
        rd_word = 16'h0000;
        if (s_axi_rready && cur.rvalid) begin
            nxt.rvalid = 1'b0;
        end
        if (do_read) begin
            case (reg_index(s_axi_araddr))
                IDX_EXPANSION: begin
                    rd_word = expansion_word(cur);
                    // Read clears the latch, but a page in this cycle still wins
                    nxt.page_rx = page_event;
                end
                IDX_NP_TX: rd_word = np_tx_word(cur.np_tx);
                IDX_PARTNER_NP: rd_word = is_1000x ? cur.partner_np : 16'h0000;
                IDX_MODE_CTRL: rd_word = {14'h0000, cur.mode};
                IDX_IRQ_STATUS: rd_word = {13'h0000, cur.irq_status};
                IDX_IRQ_MASK: rd_word = {13'h0000, cur.irq_mask};
                default: rd_word = 16'h0000;
            endcase
            nxt.rvalid = 1'b1;
            nxt.rdata = {16'h0000, rd_word};
            nxt.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (!mapped(s_axi_araddr)) begin
                nxt.rdata = 32'h00000000;
                nxt.page_rx = cur.page_rx | page_event;
            end
        end

        nxt.irq = |(nxt.irq_status & nxt.irq_mask);

        if (sw_reset) begin
            // Soft reset leaves the bus state and the interrupt registers alone
            nxt.np_tx = reset_state().np_tx;
            nxt.partner_np = PARTNER_NP_RESET;
            nxt.partner_np_able = 1'b0;
            nxt.page_rx = 1'b0;
            nxt.partner_an_able = 1'b0;
            nxt.cfg_matches = 2'h0;
            nxt.np_loaded = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= reset_state();
        end else begin
            cur <= nxt;
        end
    end

    // Ready terms are taken from flops so every output except np_tx_active, a decode of the mode flops, stays registered
    assign s_axi_awready = !cur.aw_held;
    assign s_axi_wready = !cur.w_held;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign tx_next_page = cur.np_tx;
    assign next_page_loaded = cur.np_loaded;
    assign np_tx_active = (cur.mode == MODE_1000X);
    assign fiber_mode = cur.mode;
    assign irq = cur.irq;
endmodule : fiber_autoneg_next_page
`default_nettype wire

// *** fiber_np_asserts.sv ***
// Purpose: Port-level checks for the fiber next-page register bank
// Assumes: Bound to fiber_autoneg_next_page, one clock domain
// Notes: Register index is tracked from the address handshakes
`timescale 1ns/1ps
`default_nettype none
module fiber_np_asserts
    import fiber_np_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sw_reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rx_page_s rx_page,
    input wire np_tx_s tx_next_page,
    input wire logic next_page_loaded,
    input wire logic np_tx_active,
    input wire logic [1:0] fiber_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] aw_q;
    logic [31:0] ar_q;
    // Addresses are gone after the handshake, so keep them for later checks
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
    sequence wr_both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_exp_s;
        s_axi_rvalid && ar_q == {26'h0, IDX_EXPANSION, 2'h0};
    endsequence
    wr_resp_a: assert property (wr_both_s |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    exp_fixed_a: assert property (rd_exp_s |->
        s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[2]) else $error("expansion fixed bits");
    exp_partner_a: assert property (rd_exp_s ##0 !np_tx_active |-> !s_axi_rdata[3])
        else $error("partner flag outside 1000X");
    load_cause_a: assert property (next_page_loaded |->
        np_tx_active && aw_q == {26'h0, IDX_NP_TX, 2'h0}) else $error("stray load pulse");
    mode_flag_a: assert property (np_tx_active == (fiber_mode == MODE_1000X))
        else $error("active flag vs mode");
    tog_flip_a: assert property (rx_page.valid && !sw_reset |=>
        tx_next_page.toggle != $past(tx_next_page.toggle)) else $error("toggle kept");
    tog_hold_a: assert property (!rx_page.valid && !sw_reset |=>
        $stable(tx_next_page.toggle)) else $error("toggle moved");
    soft_rst_a: assert property (sw_reset |=> tx_next_page ==
        {1'b0, NP_MSG_PAGE_RESET, 2'b00, NP_FIELD_RESET}) else $error("soft reset value");
endmodule : fiber_np_asserts
bind fiber_autoneg_next_page fiber_np_asserts i_fiber_np_asserts (.aclk, .aresetn, .sw_reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .rx_page, .tx_next_page, .next_page_loaded,
    .np_tx_active, .fiber_mode);
`default_nettype wire

// *** fiber_link_partner.sv ***
// Purpose: Far-end model sending pages, config groups and link loss
// Assumes: Tasks are called just after a rising edge
// Notes: Idle data shows the inverted last word, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module fiber_link_partner
    import fiber_np_pkg::*;
(
    input wire logic aclk,
    output rx_page_s rx_page,
    output logic link_down,
    output logic rx_sync,
    output logic cfg_word_valid,
    output logic [15:0] cfg_word
);
    initial begin
        rx_page = '0;
        link_down = 1'b0;
        rx_sync = 1'b0;
        cfg_word_valid = 1'b0;
        cfg_word = 16'h0000;
    end
    task automatic page(input logic np, input logic [15:0] w, input int gap);
        repeat (gap) @(posedge aclk);
        rx_page <= '{1'b1, np, w};
        @(posedge aclk);
        rx_page <= '{1'b0, np, ~w};
    endtask : page
    task automatic cfg(input logic [15:0] w, input int n);
        repeat (n) begin
            cfg_word <= w;
            cfg_word_valid <= 1'b1;
            @(posedge aclk);
            cfg_word <= ~w;
            cfg_word_valid <= 1'b0;
            @(posedge aclk);
        end
    endtask : cfg
    task automatic drop;
        link_down <= 1'b1;
        @(posedge aclk);
        link_down <= 1'b0;
    endtask : drop
    task automatic sync(input logic s);
        rx_sync <= s;
        @(posedge aclk);
    endtask : sync
endmodule : fiber_link_partner
`default_nettype wire

// *** fiber_autoneg_next_page_tb_top.sv ***
// Purpose: Self-checking bench for the fiber next-page register bank
// Assumes: Partner model drives page, config and link events
// Notes: Random words come from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module fiber_autoneg_next_page_tb_top
    import fiber_np_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, sw_reset = 1'b0, an_enable = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic next_page_loaded, np_tx_active, irq, link_down, rx_sync, cfg_word_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, fiber_mode, lresp;
    logic [15:0] cfg_word;
    rx_page_s rx_page;
    np_tx_s tx_next_page;
    int num_errors = 0, comparisons = 0, loads = 0;
    logic [31:0] seed = 32'hD347575B;
    logic tog = 1'b0;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (next_page_loaded === 1'b1) loads <= loads + 1;
    fiber_autoneg_next_page i_fiber_autoneg_next_page (.aclk, .aresetn, .sw_reset,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rx_page, .link_down, .rx_sync, .cfg_word_valid,
        .cfg_word, .an_enable, .tx_next_page, .next_page_loaded, .np_tx_active,
        .fiber_mode, .irq);
    fiber_link_partner i_fiber_link_partner (.aclk, .rx_page, .link_down, .rx_sync,
        .cfg_word_valid, .cfg_word);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] exp_tx(input logic [15:0] d, input logic t);
        return (d & 16'hB7FF) | {4'h0, t, 11'h000};
    endfunction : exp_tx
    function automatic logic [15:0] exp_ex(input logic p, input logic r, input logic a);
        return {12'h000, p, 1'b1, r, a};
    endfunction : exp_ex
    task automatic close_out;
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100) begin
            num_errors++;
            close_out();
        end
    endtask : tick
    task automatic wr(input logic [3:0] ix, input logic [15:0] d);
        int n = 0;
        s_axi_awaddr <= {26'h0, ix, 2'h0};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        // One idle edge so a following call never reassigns a strobe in this step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [3:0] ix, output logic [31:0] d);
        int n = 0;
        s_axi_araddr <= {26'h0, ix, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        lresp = s_axi_rresp;
        @(posedge aclk);
    endtask : rd
    task automatic wait_irq(input logic v);
        int n = 0;
        while (irq !== v && n < 8) tick(n);
        `CHK(irq, v)
    endtask : wait_irq
    initial begin
        logic [31:0] d;
        logic [15:0] w, e;
        int k;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(IDX_EXPANSION, d); `CHK(d, {16'h0, exp_ex(0, 0, 0)})
        rd(IDX_NP_TX, d); `CHK(d, {16'h0, exp_tx(16'h2001, 1'b0)})
        rd(IDX_PARTNER_NP, d); `CHK(d, 32'h0)
        rd(4'hC, d); `CHK({lresp, d}, {RESP_SLVERR, 32'h0})
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MODE_CTRL, 16'(m));
            `CHK(fiber_mode, m[1:0])
            seed = lfsr(seed);
            // Gap grows with mode so prompt and slow partners both occur
            i_fiber_link_partner.page(1'b0, {1'b1, seed[14:0]}, m);
            tog = ~tog;
            rd(IDX_EXPANSION, d); `CHK(d[15:0], exp_ex(m == 1, 1, 0))
            rd(IDX_EXPANSION, d); `CHK(d[1], 1'b0)
            rd(IDX_PARTNER_NP, d); `CHK(d, 32'h0)
            w = seed[31:16];
            i_fiber_link_partner.page(1'b1, w, 0);
            tog = ~tog;
            rd(IDX_PARTNER_NP, d); `CHK(d[15:0], m == 1 ? w : 16'h0)
            k = loads;
            w = m == 0 ? 16'hFFFF : seed[15:0];
            e = exp_tx(w, tog);
            wr(IDX_NP_TX, w);
            repeat (2) @(posedge aclk);
            `CHK(loads - k, int'(m == 1))
            rd(IDX_NP_TX, d); `CHK(d[15:0], e)
            `CHK(tx_next_page, {e[15], e[13:0]})
            i_fiber_link_partner.drop();
            rd(IDX_PARTNER_NP, d); `CHK(d, 32'h0)
            rd(IDX_EXPANSION, d); `CHK(d[3], 1'b0)
        end
        wr(IDX_MODE_CTRL, 16'(MODE_1000X));
        i_fiber_link_partner.sync(1'b1);
        i_fiber_link_partner.cfg(16'h01A0, 3);
        rd(IDX_EXPANSION, d); `CHK(d[0], 1'b0)
        an_enable <= 1'b1;
        i_fiber_link_partner.cfg(16'h01C0, 2);
        rd(IDX_EXPANSION, d); `CHK(d[0], 1'b0)
        i_fiber_link_partner.cfg(16'h01C0, 1);
        rd(IDX_EXPANSION, d); `CHK(d[0], 1'b1)
        i_fiber_link_partner.sync(1'b0);
        rd(IDX_EXPANSION, d); `CHK(d[0], 1'b0)
        wr(IDX_IRQ_MASK, 16'h0004);
        i_fiber_link_partner.drop();
        wait_irq(1'b1);
        wr(IDX_IRQ_MASK, 16'h0000);
        wait_irq(1'b0);
        wr(IDX_IRQ_MASK, 16'h0004);
        wait_irq(1'b1);
        wr(IDX_IRQ_STATUS, 16'h0007);
        wait_irq(1'b0);
        i_fiber_link_partner.page(1'b1, 16'h1234, 0);
        sw_reset <= 1'b1;
        @(posedge aclk);
        sw_reset <= 1'b0;
        rd(IDX_NP_TX, d); `CHK(d[15:0], exp_tx(16'h2001, 1'b0))
        rd(IDX_PARTNER_NP, d); `CHK(d, 32'h0)
        close_out();
    end
endmodule : fiber_autoneg_next_page_tb_top
`default_nettype wire
